// ===== include/bdc_if.sv
`timescale 1ns/1ps
// Avalon-MM link between firmware master and backup domain
interface bdc_if;
  logic [5:0]  address;      // Word address
  logic        read;         // Read request
  logic        write;        // Write request
  logic [31:0] writedata;    // Write data
  logic [3:0]  byteenable;   // Byte lanes
  logic [31:0] readdata;     // Read data
  logic        waitrequest;  // Slave stall
  modport device (input address, read, write, writedata, byteenable, output readdata, waitrequest);
  modport host   (output address, read, write, writedata, byteenable, input readdata, waitrequest);
endinterface

// ===== include/bdc_pkg.sv
// Behaviour
// [R1] Mode 0: main when brownout ok, else higher
// [R2] Modes 1 to 3 always pick backup
// [R3] Key 3C enables supercapacitor charging
// [R4] Never charge key with battery attached
// [R5] Thirty-two bytes retained storage
// [R6] Firmware reset field resets whole domain
// [R7] Measure bit taps scaled backup supply
// [R8] Divide domain clock to one-second tick
// [R9] Clock source select: crystal or alternate
// [R10] Oscillator enable bit drives crystal on
// [R11] Clear bypass before enabling crystal
// [R12] Program divider 32768 for crystal
// [R13] Prefer crystal directly over alternate
// [R14] Firmware reaches registers over bus
// [R15] Alarm can raise processor interrupt
// [R16] Only cold start or firmware resets domain
// [R17] Bypass first, divider 32768/60/50 for inputs
package bdc_pkg;
  // Word addresses of the register map
  localparam logic [5:0] BDC_CTL_ADDR    = 6'h00;
  localparam logic [5:0] BDC_RST_ADDR    = 6'h01;
  localparam logic [5:0] BDC_STAT_ADDR   = 6'h02;
  localparam logic [5:0] BDC_IRQ_ADDR    = 6'h03;
  localparam logic [5:0] BDC_MASK_ADDR   = 6'h04;
  localparam logic [5:0] BDC_ALARM_ADDR  = 6'h05;
  localparam logic [5:0] BDC_SECS_ADDR   = 6'h06;
  localparam logic [5:0] BDC_RETAIN_BASE = 6'h08;
  localparam int         BDC_RETAIN_WORDS = 8;
  // Control register field positions
  localparam int BDC_SUP_LSB    = 0;
  localparam int BDC_SEL_BIT    = 2;
  localparam int BDC_OSCEN_BIT  = 3;
  localparam int BDC_BYP_BIT    = 4;
  localparam int BDC_MEAS_BIT   = 5;
  localparam int BDC_KEY_LSB    = 8;
  localparam int BDC_DIV_LSB    = 16;
  localparam logic [7:0]  BDC_CHARGE_KEY = 8'h3c;
  localparam logic [15:0] BDC_DIV_RESET  = 16'h8000;
  // Interrupt bits
  localparam int BDC_IRQ_TICK  = 0;
  localparam int BDC_IRQ_ALARM = 1;
  // Tick source encoding
  typedef enum logic {BDC_SRC_CRYSTAL, BDC_SRC_ALT} bdc_src_type;
endpackage

// ===== src/bdc_device.sv
`timescale 1ns/1ps
// Backup domain control: supply switch, charger key, tick prescaler,
// retained storage, alarm and interrupt.
module bdc_device
  import bdc_pkg::*;
(
  input  wire logic        sys_clk,          // Domain clock
  input  wire logic        rst_n,            // Cold-start reset, active low
  bdc_if.device            bus,              // Firmware register bus
  input  wire logic        main_higher,      // Comparator: main above backup
  input  wire logic        brownout_enabled, // Brownout detector enabled
  input  wire logic        brownout_flag,    // Brownout detected
  input  wire logic        crystal_osc_clk,  // Crystal oscillator output
  input  wire logic        low_freq_system_clock, // Alternate source
  output logic             use_backup_supply,// 1 backup rail, 0 main rail
  output logic             charge_en,        // Supercapacitor charger on
  output logic             measure_tap_en,   // Scaled backup to mux bus
  output logic             crystal_osc_on,   // Oscillator enable
  output logic             crystal_osc_bypass_o, // Oscillator bypass
  output logic             second_tick,      // One-cycle second pulse
  output logic             irq               // Level interrupt
);
  // Synchronisers: first stage read only by second stage
  logic       xtal_s1_reg, xtal_s2_reg;
  logic       alt_s1_reg, alt_s2_reg;
  logic       bo_s1_reg, bo_s2_reg;
  logic       mh_s1_reg, mh_s2_reg;
  logic       be_s1_reg, be_s2_reg;

  typedef struct packed {
    logic [1:0]  sup;          // supply_select_ctl
    logic        src;          // clock_source_sel
    logic        osc_en;       // crystal_osc_enable
    logic        bypass;       // crystal_osc_bypass
    logic        meas;         // supply_measure_en
    logic        charge;       // Charger armed by key
    logic [15:0] div;          // tick_divider
    logic [15:0] cnt;          // Source edge count
    logic        src_prev;     // Previous synced source level
    logic [31:0] secs;         // Seconds counter
    logic [31:0] alarm;        // Alarm match value
    logic [1:0]  stat;         // Sticky events
    logic [1:0]  mask;         // Interrupt mask
    logic        tick;         // Tick pulse
    logic        ack;          // Bus answer strobe
    logic [31:0] rdata;        // Read data
    logic [BDC_RETAIN_WORDS-1:0][31:0] ret; // Retained bytes
  } bdc_dev_type;
  bdc_dev_type s_reg, s_next;

  // Two-flop synchronisers for pins and foreign clocks
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      xtal_s1_reg <= '0;
      xtal_s2_reg <= '0;
      alt_s1_reg  <= '0;
      alt_s2_reg  <= '0;
      {bo_s1_reg, bo_s2_reg, mh_s1_reg, mh_s2_reg, be_s1_reg, be_s2_reg} <= '0;
    end else begin
      xtal_s1_reg <= crystal_osc_clk;
      xtal_s2_reg <= xtal_s1_reg;
      alt_s1_reg  <= low_freq_system_clock;
      alt_s2_reg  <= alt_s1_reg;
      bo_s1_reg   <= brownout_flag;
      bo_s2_reg   <= bo_s1_reg;
      mh_s1_reg   <= main_higher;
      mh_s2_reg   <= mh_s1_reg;
      be_s1_reg   <= brownout_enabled;
      be_s2_reg   <= be_s1_reg;
    end
  end

  logic xtal_lvl, alt_lvl, src_lvl, src_rise, alarm_hit;
  logic [1:0] evt;
  logic [31:0] wmask;
  assign xtal_lvl = xtal_s2_reg;
  assign alt_lvl  = alt_s2_reg;

  // Next-state logic for all registers in s_reg
  always_comb begin
    s_next   = s_reg;
    s_next.tick = 1'b0;
    s_next.ack  = 1'b0;
    // Gated crystal only counts while enabled
    src_lvl  = (s_reg.src == BDC_SRC_ALT) ? alt_lvl : (xtal_lvl & s_reg.osc_en); // R9 R10
    src_rise = src_lvl & ~s_reg.src_prev;
    s_next.src_prev = src_lvl;
    alarm_hit = 1'b0;
    wmask = {{8{bus.byteenable[3]}}, {8{bus.byteenable[2]}},
             {8{bus.byteenable[1]}}, {8{bus.byteenable[0]}}};
    // Prescaler: divide source edges to one-second ticks
    if (src_rise) begin
      if (s_reg.cnt >= s_reg.div - 16'h0001) begin  // R8
        s_next.cnt  = '0;
        s_next.tick = 1'b1;
        s_next.secs = s_reg.secs + 32'h0000_0001;
        alarm_hit   = (s_reg.secs + 32'h0000_0001) == s_reg.alarm; // R15
      end else begin
        s_next.cnt = s_reg.cnt + 16'h0001;
      end
    end
    evt = '0;
    evt[BDC_IRQ_TICK]  = s_next.tick;
    evt[BDC_IRQ_ALARM] = alarm_hit;
    // Bus access: one wait cycle, answer on next edge
    if ((bus.read || bus.write) && !s_reg.ack) begin
      s_next.ack = 1'b1;
      s_next.rdata = '0;
      if (bus.write) begin
        if (bus.address == BDC_CTL_ADDR) begin
          if (bus.byteenable[0]) begin
            s_next.sup    = bus.writedata[BDC_SUP_LSB +: 2];
            s_next.src    = bus.writedata[BDC_SEL_BIT];
            s_next.osc_en = bus.writedata[BDC_OSCEN_BIT];
            s_next.bypass = bus.writedata[BDC_BYP_BIT];
            s_next.meas   = bus.writedata[BDC_MEAS_BIT];
          end
          if (bus.byteenable[1]) begin
            s_next.charge = (bus.writedata[BDC_KEY_LSB +: 8] == BDC_CHARGE_KEY); // R3
          end
          if (bus.byteenable[2] && bus.byteenable[3]) begin
            s_next.div = bus.writedata[BDC_DIV_LSB +: 16];
          end
        end else if (bus.address == BDC_RST_ADDR) begin
          if (bus.byteenable[0] && bus.writedata[0]) begin  // R6 R16
            s_next = '0;
            s_next.div = BDC_DIV_RESET;
            s_next.ack = 1'b1;
            evt = '0;
          end
        end else if (bus.address == BDC_IRQ_ADDR) begin
          s_next.stat = s_reg.stat & ~(bus.writedata[1:0] & wmask[1:0]);
        end else if (bus.address == BDC_MASK_ADDR) begin
          if (bus.byteenable[0]) begin
            s_next.mask = bus.writedata[1:0];
          end
        end else if (bus.address == BDC_ALARM_ADDR) begin
          s_next.alarm = (s_reg.alarm & ~wmask) | (bus.writedata & wmask);
        end else if (bus.address >= BDC_RETAIN_BASE) begin
          s_next.ret[bus.address[2:0]] = (s_reg.ret[bus.address[2:0]] & ~wmask)
                                         | (bus.writedata & wmask); // R5
        end
      end else begin
        if (bus.address == BDC_CTL_ADDR) begin
          s_next.rdata[BDC_SUP_LSB +: 2]  = s_reg.sup;
          s_next.rdata[BDC_SEL_BIT]       = s_reg.src;
          s_next.rdata[BDC_OSCEN_BIT]     = s_reg.osc_en;
          s_next.rdata[BDC_BYP_BIT]       = s_reg.bypass;
          s_next.rdata[BDC_MEAS_BIT]      = s_reg.meas;
          s_next.rdata[BDC_KEY_LSB]       = s_reg.charge;
          s_next.rdata[BDC_DIV_LSB +: 16] = s_reg.div;
        end else if (bus.address == BDC_STAT_ADDR) begin
          s_next.rdata[0] = use_backup_supply;
          s_next.rdata[1] = s_reg.charge;
        end else if (bus.address == BDC_IRQ_ADDR) begin
          s_next.rdata[1:0] = s_reg.stat;
        end else if (bus.address == BDC_MASK_ADDR) begin
          s_next.rdata[1:0] = s_reg.mask;
        end else if (bus.address == BDC_ALARM_ADDR) begin
          s_next.rdata = s_reg.alarm;
        end else if (bus.address == BDC_SECS_ADDR) begin
          s_next.rdata = s_reg.secs;
        end else if (bus.address >= BDC_RETAIN_BASE) begin
          s_next.rdata = s_reg.ret[bus.address[2:0]];
        end
      end
    end
    // Events set after clear so a same-cycle event wins
    s_next.stat = s_next.stat | evt;
  end

  // State register; rst_n is the cold-start reset only
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin  // R16
      s_reg     <= '0;
      s_reg.div <= BDC_DIV_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // Supply switch: backup in modes 1 to 3; mode 0 brownout-qualified main, else the higher rail
  assign use_backup_supply = (s_reg.sup != 2'h0) ? 1'b1 :          // R2
                             (be_s2_reg && !bo_s2_reg) ? 1'b0 : !mh_s2_reg; // R1
  assign charge_en            = s_reg.charge;   // R3
  assign measure_tap_en       = s_reg.meas;     // R7
  assign crystal_osc_on       = s_reg.osc_en;   // R10
  assign crystal_osc_bypass_o = s_reg.bypass;
  assign second_tick          = s_reg.tick;
  assign irq                  = |(s_reg.stat & s_reg.mask); // R15
  assign bus.readdata         = s_reg.rdata;
  assign bus.waitrequest      = !s_reg.ack;     // R14
endmodule

// ===== src/bdc_firmware.sv
`timescale 1ns/1ps
// Firmware-side master: runs one word access per command
module bdc_firmware
  import bdc_pkg::*;
(
  input  wire logic        sys_clk,    // System clock
  input  wire logic        rst_n,      // Async reset, active low
  bdc_if.host              bus,        // Bus to the device
  input  wire logic        cmd_valid,  // Command request
  input  wire logic        cmd_write,  // 1 write, 0 read
  input  wire logic [5:0]  cmd_addr,   // Word address
  input  wire logic [31:0] cmd_wdata,  // Write data
  output logic             cmd_ready,  // Idle, may accept
  output logic             rsp_valid,  // One-cycle answer pulse
  output logic [31:0]      rsp_rdata   // Read data
);
  typedef enum logic {FW_IDLE, FW_BUSY} bdc_fw_state_type;
  typedef struct packed {
    bdc_fw_state_type st;
    logic             wr;
    logic [5:0]       addr;
    logic [31:0]      wdata;
    logic             done;
    logic [31:0]      rdata;
  } bdc_fw_type;
  bdc_fw_type s_reg, s_next;

  // Command decode; software keeps bypass/enable order and key rules
  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    unique case (s_reg.st)
      FW_IDLE: begin
        if (cmd_valid) begin  // R4 R11 R12 R13 R17 are the caller's duty
          s_next.st    = FW_BUSY;
          s_next.wr    = cmd_write;
          s_next.addr  = cmd_addr;
          s_next.wdata = cmd_wdata;
        end
      end
      FW_BUSY: begin
        if (!bus.waitrequest) begin  // Answer taken at this edge only
          s_next.st    = FW_IDLE;
          s_next.done  = 1'b1;
          s_next.rdata = s_reg.wr ? s_reg.rdata : bus.readdata;
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign bus.read       = (s_reg.st == FW_BUSY) && !s_reg.wr;
  assign bus.write      = (s_reg.st == FW_BUSY) && s_reg.wr;
  assign bus.address    = s_reg.addr;
  assign bus.writedata  = s_reg.wdata;
  assign bus.byteenable = 4'hf;
  assign cmd_ready      = (s_reg.st == FW_IDLE);
  assign rsp_valid      = s_reg.done;
  assign rsp_rdata      = s_reg.rdata;
endmodule

// ===== tb/bdc_assertions.sv
`timescale 1ns/1ps
// Bus checks on the link between firmware master and device
module bdc_assertions
  import bdc_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic [5:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [3:0]  byteenable,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest
);
  logic        req;            // Any request open
  logic        ack;            // Answer cycle
  logic [31:0] ctl_shadow_reg; // Expected control contents
  assign req = read | write;
  assign ack = req & ~waitrequest;
  // Shadow of control; a firmware reset must bring back the cold value
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_shadow_reg <= 32'h8000_0000;
    end else if (ack && write && address == BDC_RST_ADDR && writedata[0]) begin
      ctl_shadow_reg <= 32'h8000_0000;
    end else if (ack && write && address == BDC_CTL_ADDR && byteenable == 4'hf) begin
      ctl_shadow_reg <= writedata;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  chk_no_dual_request: assert property (!(read && write))
    else $error("read and write high together");
  chk_idle_stall: assert property (!req |-> waitrequest)
    else $error("waitrequest low without request");
  chk_one_wait: assert property ($rose(req) |-> waitrequest ##1 (req && !waitrequest))
    else $error("answer not after exactly one wait cycle");
  chk_request_held: assert property (req && waitrequest |=> req && $stable(address) && $stable(writedata))
    else $error("request changed while stalled");
  chk_release_after: assert property (ack |=> !req)
    else $error("request not released after answer");
  chk_unmapped_zero: assert property (ack && read && address == 6'h07 |-> readdata == 32'h0)
    else $error("unmapped address read nonzero");
  chk_ctl_fields: assert property (ack && read && address == BDC_CTL_ADDR |-> readdata[5:0] == ctl_shadow_reg[5:0])
    else $error("control fields read back wrong");
  chk_key_armed: assert property (ack && read && address == BDC_CTL_ADDR |->
    readdata[8] == (ctl_shadow_reg[15:8] == BDC_CHARGE_KEY))
    else $error("charge key armed flag wrong");
  chk_divider_back: assert property (ack && read && address == BDC_CTL_ADDR |->
    readdata[31:16] == ctl_shadow_reg[31:16])
    else $error("divider read back wrong");
  cov_write: cover property (ack && write);
  cov_read: cover property (ack && read);
  cov_fw_reset: cover property (ack && write && address == BDC_RST_ADDR);
endmodule

// ===== tb/test_backup_domain_control.sv
`timescale 1ns/1ps
// Top bench: firmware master and device joined, random control traffic
module test_backup_domain_control;
  import bdc_pkg::*;
  logic        sys_clk = 0, rst_n = 0, cmd_valid = 0, cmd_write = 0;
  logic [5:0]  cmd_addr = 0;
  logic [31:0] cmd_wdata = 0, rsp_rdata, r, d;
  logic        cmd_ready, rsp_valid, main_higher = 0, brownout_enabled = 0, brownout_flag = 0;
  logic        crystal_osc_clk = 0, low_freq_system_clock = 0, eb;
  logic        use_backup_supply, charge_en, measure_tap_en, crystal_osc_on, crystal_osc_bypass_o, second_tick, irq;
  logic [31:0] w [8];       // Retained words written
  logic [7:0]  cnt = 0;     // Slow source divider
  int          mismatches = 0, samples_checked = 0, seed = 88, ticks = 0, tot = 0, n;
  bdc_if bus();
  bdc_firmware i_bdc_firmware(.sys_clk(sys_clk), .rst_n(rst_n), .bus(bus), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
  bdc_device i_bdc_device(.sys_clk(sys_clk), .rst_n(rst_n), .bus(bus), .main_higher(main_higher),
    .brownout_enabled(brownout_enabled), .brownout_flag(brownout_flag), .crystal_osc_clk(crystal_osc_clk),
    .low_freq_system_clock(low_freq_system_clock), .use_backup_supply(use_backup_supply),
    .charge_en(charge_en), .measure_tap_en(measure_tap_en), .crystal_osc_on(crystal_osc_on),
    .crystal_osc_bypass_o(crystal_osc_bypass_o), .second_tick(second_tick), .irq(irq));
  bdc_assertions i_bdc_assertions(.sys_clk(sys_clk), .rst_n(rst_n), .address(bus.address), .read(bus.read),
    .write(bus.write), .writedata(bus.writedata), .byteenable(bus.byteenable), .readdata(bus.readdata),
    .waitrequest(bus.waitrequest));
  always #5 sys_clk = ~sys_clk;
  // Slow sources far below the system clock, as the synchronisers need
  always @(posedge sys_clk) begin
    cnt <= cnt + 8'h01;
    crystal_osc_clk <= cnt[3];
    low_freq_system_clock <= cnt[4];
    if (second_tick === 1'b1) begin
      ticks++;
      tot++;
    end
  end
  // Expected supply choice
  function automatic logic exp_backup(input logic [1:0] m, input logic en, fl, hi);
    return (m != 2'h0) ? 1'b1 : ((en && !fl) ? 1'b0 : !hi);
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One firmware command, waits for its answer pulse
  task automatic fw(input logic wr, input logic [5:0] a, input logic [31:0] dat, output logic [31:0] q);
    int k;
    k = 0;
    @(posedge sys_clk);
    while (cmd_ready !== 1'b1) @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd_write <= wr;
    cmd_addr <= a;
    cmd_wdata <= dat;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    while (rsp_valid !== 1'b1 && k < 50) begin
      @(posedge sys_clk);
      k++;
    end
    q = rsp_rdata;
    if (k == 50) begin
      mismatches++;
      results();
    end
  endtask
  task automatic results();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #300000;
    mismatches++;
    results();
  end
  initial begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    fw(1'b0, BDC_CTL_ADDR, 32'h0, r);
    cmp(r & 32'hffff_013f, 32'h8000_0000);
    // All supply modes with random comparator levels, key and tap bits
    for (int i = 0; i < 16; i++) begin
      d = {16'h8000, (i[0] ? BDC_CHARGE_KEY : 8'($random(seed))), 2'h0, 3'($random(seed)), 1'b0, 2'(i)};
      main_higher <= 1'($random(seed));
      brownout_enabled <= 1'($random(seed));
      brownout_flag <= 1'($random(seed));
      fw(1'b1, BDC_CTL_ADDR, d, r);
      repeat (4) @(posedge sys_clk);
      eb = exp_backup(d[1:0], brownout_enabled, brownout_flag, main_higher);
      cmp(use_backup_supply, eb);
      cmp(charge_en, d[15:8] == BDC_CHARGE_KEY);
      cmp(measure_tap_en, d[5]);
      cmp(crystal_osc_on, d[3]);
      cmp(crystal_osc_bypass_o, d[4]);
      fw(1'b0, BDC_STAT_ADDR, 32'h0, r);
      cmp(r[0], eb);
    end
    // Retained storage, then an unmapped place
    for (int i = 0; i < 8; i++) begin
      w[i] = $random(seed);
      fw(1'b1, BDC_RETAIN_BASE + 6'(i), w[i], r);
    end
    for (int i = 0; i < 8; i++) begin
      fw(1'b0, BDC_RETAIN_BASE + 6'(i), 32'h0, r);
      cmp(r, w[i]);
    end
    fw(1'b1, 6'h07, 32'hffff_ffff, r);
    fw(1'b0, 6'h07, 32'h0, r);
    cmp(r, 32'h0);
    // Ticks from each source at divider 4
    fw(1'b1, BDC_ALARM_ADDR, 32'h2, r);
    for (int s = 0; s < 2; s++) begin
      fw(1'b1, BDC_CTL_ADDR, {16'h0004, 12'h0, 1'b1, s[0], 2'h0}, r);
      ticks = 0;
      n = s ? 10 : 20;
      repeat (1280) @(posedge sys_clk);
      cmp(32'(ticks >= n - 1 && ticks <= n + 1), 32'h1);
      cmp(crystal_osc_on, 1'b1);
    end
    fw(1'b1, BDC_CTL_ADDR, 32'h0004_0000, r);
    cmp(crystal_osc_on, 1'b0);
    fw(1'b0, BDC_SECS_ADDR, 32'h0, r);
    cmp(r, tot);
    // Interrupt raised, masked, cleared
    fw(1'b0, BDC_IRQ_ADDR, 32'h0, r);
    cmp(r[1:0], 2'h3);
    fw(1'b1, BDC_MASK_ADDR, 32'h1, r);
    repeat (2) @(posedge sys_clk);
    cmp(irq, 1'b1);
    fw(1'b1, BDC_MASK_ADDR, 32'h0, r);
    repeat (2) @(posedge sys_clk);
    cmp(irq, 1'b0);
    fw(1'b1, BDC_IRQ_ADDR, 32'h3, r);
    fw(1'b1, BDC_MASK_ADDR, 32'h3, r);
    fw(1'b0, BDC_IRQ_ADDR, 32'h0, r);
    cmp(r[1:0], 2'h0);
    cmp(irq, 1'b0);
    // Firmware reset brings back the cold state
    fw(1'b1, BDC_CTL_ADDR, 32'h0004_3c21, r);
    cmp(charge_en, 1'b1);
    fw(1'b1, BDC_RST_ADDR, 32'h1, r);
    cmp(charge_en, 1'b0);
    fw(1'b0, BDC_CTL_ADDR, 32'h0, r);
    cmp(r & 32'hffff_013f, 32'h8000_0000);
    cmp(measure_tap_en, 1'b0);
    fw(1'b0, BDC_SECS_ADDR, 32'h0, r);
    cmp(r, 32'h0);
    fw(1'b0, BDC_RETAIN_BASE, 32'h0, r);
    cmp(r, 32'h0);
    // External square wave: bypass set first, then enable, divider 50
    fw(1'b1, BDC_CTL_ADDR, 32'h0032_0010, r);
    fw(1'b1, BDC_CTL_ADDR, 32'h0032_0018, r);
    cmp(crystal_osc_bypass_o, 1'b1);
    cmp(crystal_osc_on, 1'b1);
    fw(1'b0, BDC_CTL_ADDR, 32'h0, r);
    cmp(r[31:16], 16'h0032);
    results();
  end
endmodule
